// ---- core/tone_pair_program_loader.sv ----
`timescale 1ns/10ps
`include "tone_loader_params.svh"

// Overview of operation
// RULE1 - Four transmit pairs, each with two tones holding frequency and level.
// RULE2 - A tone written with zero frequency and zero level is silent.
// RULE3 - Transmit load opens with header 8000 hex; values 0 to 3FFF.
// RULE4 - Up to seventeen words: per pair f1, l1, f2, l2 in order.
// RULE5 - Host encodes frequency as hertz times 3.414, at most 3.4 kHz.
// RULE6 - Host encodes level as Vrms times 93780 over supply voltage.
// RULE7 - Reset leaves pairs one to three silent, pair four 2130+2750 Hz.
// RULE8 - Receive load opens with header 8001 hex; values 0 to 7FFF.
// RULE9 - Receive load is 27 words: two groups of ten coefficients plus timing.
// RULE10 - Coefficients are 15-bit two's complement, coefficient times 8192.
// RULE11 - Detector times ncycles input cycles and accepts within min and max.
// RULE12 - Time limits count ticks of a 9.6 kHz timer.
// RULE13 - Level detector switches on and off at two thresholds.
// RULE14 - Receive changes apply only on next entry into programmed detect mode.
// RULE15 - After reset the receive detector acts as a 2130+2750 Hz detector.
// RULE16 - Flag clears on each write and sets again once the word is absorbed.
// RULE17 - Programming memory cleared on reset or powersave entry.
// RULE18 - Host leaves mode settings alone until the flag returns to one.
// RULE19 - Programming register is write-only, 16 bits, at bus address E8.
// RULE20 - Tone detected only when frequency in range and level on together.
module tone_pair_program_loader
	import tone_loader_pkg::*;
#(
	parameter int          TICK_DIV   = `TICK_CYCLES,
	parameter logic [15:0] DEF_NCYC1  = 16'h0010,
	parameter logic [15:0] DEF_MIN1   = 16'h0046,
	parameter logic [15:0] DEF_MAX1   = 16'h004A,
	parameter logic [15:0] DEF_NCYC2  = 16'h0010,
	parameter logic [15:0] DEF_MIN2   = 16'h0037,
	parameter logic [15:0] DEF_MAX2   = 16'h0039,
	parameter logic [15:0] LVL_ON_TH  = 16'h0100,
	parameter logic [15:0] LVL_OFF_TH = 16'h00C0
) (
	input  wire logic          ref_clk,
	input  wire logic          nrst,
	input  wire logic          clk_en,
	input  wire logic          powersave,
	input  wire logic          prog_wr,
	input  wire logic [7:0]    prog_addr,
	input  wire logic [15:0]   prog_data,
	output logic               prog_flag,
	input  wire logic          tx_rd_en,
	input  wire logic [3:0]    tx_rd_idx,
	output logic      [15:0]   tx_rd_data,
	output logic      [7:0]    tx_tone_silent,
	input  wire logic          rx_mode_enter,
	output logic      [389:0]  rx_coef_active,
	output logic               rx_default_mode,
	input  wire logic [1:0]    cycle_done,
	input  wire logic [31:0]   level_mag,
	output logic      [1:0]    level_on,
	output logic      [1:0]    freq_ok,
	output logic      [1:0]    tone_det
);

	// ----------------------------------------------------------------
	// Loader state
	// ----------------------------------------------------------------
	load_state_e   state_q;
	logic [5:0]    widx_q;
	logic          wpend_q;
	logic [15:0]   wdata_q;
	logic          flag_q;
	logic          freq_zero_q;
	logic          rx_dflt_q;
	logic          act_dflt_q;
	logic [5:0]    cidx_q;
	logic          cvld_q;
	logic [4:0]    cdst_q;
	coef_t         act_q [0:25];

	logic          mem_we;
	logic [5:0]    mem_wa;
	logic [15:0]   mem_wd;
	logic [15:0]   copy_rd;
	logic          word_take;
	logic          hdr_word;

	// RULE19
	assign word_take = prog_wr && (prog_addr == `PROG_ADDR);
	assign hdr_word  = prog_data[`HDR_BIT];

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= ST_CLEAR;
			widx_q  <= 6'h00;
			wpend_q <= 1'b0;
			wdata_q <= 16'h0000;
		end else if (clk_en) begin
			wpend_q <= 1'b0;
			if (powersave) begin
				state_q <= ST_CLEAR; // RULE17
				widx_q  <= 6'h00;
			end else begin
				case (state_q)
					ST_CLEAR: begin
						widx_q <= widx_q + 6'h01;
						if (widx_q == `MEM_LAST) begin
							state_q <= ST_IDLE;
						end
					end
					ST_COPY: begin
						if (cidx_q == `RX_WORDS && !cvld_q) begin
							state_q <= ST_IDLE;
						end
					end
					default: begin
						if (rx_mode_enter && state_q == ST_IDLE) begin
							state_q <= ST_COPY; // RULE14
						end else if (word_take && hdr_word) begin
							// A fresh header abandons any load in progress
							widx_q <= 6'h00;
							if (prog_data == `HDR_TX) begin
								state_q <= ST_TX; // RULE3
							end else if (prog_data == `HDR_RX) begin
								state_q <= ST_RX; // RULE8
							end else begin
								state_q <= ST_IDLE;
							end
						end else if (word_take && state_q != ST_IDLE) begin
							wpend_q <= 1'b1;
							wdata_q <= prog_data;
						end else if (wpend_q) begin
							widx_q <= widx_q + 6'h01;
							if (state_q == ST_TX && widx_q == `TX_WORDS - 6'h01) begin
								state_q <= ST_IDLE; // RULE4
							end
							if (state_q == ST_RX && widx_q == `RX_WORDS - 6'h01) begin
								state_q <= ST_IDLE; // RULE9
							end
						end
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Programming flag
	// ----------------------------------------------------------------
	// Low through clearing and copying, except the first copy cycle, which still shows the idle value
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			flag_q <= 1'b0;
		end else if (clk_en) begin
			if (powersave || state_q == ST_CLEAR || state_q == ST_COPY) begin
				flag_q <= 1'b0;
			end else if (word_take) begin
				flag_q <= 1'b0; // RULE16
			end else if (!wpend_q && !rx_mode_enter) begin
				flag_q <= 1'b1; // RULE16
			end
		end
	end

	assign prog_flag = flag_q;

	// ----------------------------------------------------------------
	// Memory write path
	// ----------------------------------------------------------------
	always_comb begin
		mem_we = 1'b0;
		mem_wa = widx_q;
		mem_wd = 16'h0000;
		if (state_q == ST_CLEAR) begin
			mem_we = 1'b1; // RULE17
			if (widx_q == `TX_P4_BASE) begin
				mem_wd = `P4_F1_DEF; // RULE7
			end else if (widx_q == `TX_P4_BASE + 6'd1 || widx_q == `TX_P4_BASE + 6'd3) begin
				mem_wd = `P4_LVL_DEF;
			end else if (widx_q == `TX_P4_BASE + 6'd2) begin
				mem_wd = `P4_F2_DEF;
			end
		end else if (wpend_q && state_q == ST_TX) begin
			mem_we = 1'b1;
			mem_wd = wdata_q & `TX_VAL_MASK; // RULE1
		end else if (wpend_q && state_q == ST_RX) begin
			mem_we = 1'b1;
			mem_wa = widx_q + `RX_BASE;
			mem_wd = wdata_q & `RX_VAL_MASK; // RULE10
		end
	end

	coef_mem #(
		.AW (6),
		.DW (16)
	) u_mem (
		.ref_clk   (ref_clk),
		.clk_en    (clk_en),
		.wr_en     (mem_we),
		.wr_addr   (mem_wa),
		.wr_data   (mem_wd),
		.rd_a_addr ({2'b00, tx_rd_idx}),
		.rd_a_q    (tx_rd_data),
		.rd_b_addr (cidx_q + `RX_BASE),
		.rd_b_q    (copy_rd)
	);

	// ----------------------------------------------------------------
	// Silent-tone tracking
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			tx_tone_silent <= `SILENT_DEF; // RULE7
			freq_zero_q    <= 1'b0;
		end else if (clk_en) begin
			if (state_q == ST_CLEAR) begin
				tx_tone_silent <= `SILENT_DEF;
			end else if (wpend_q && state_q == ST_TX) begin
				if (!widx_q[0]) begin
					freq_zero_q <= (wdata_q & `TX_VAL_MASK) == 16'h0000;
				end else begin
					tx_tone_silent[widx_q[3:1]] <= freq_zero_q && ((wdata_q & `TX_VAL_MASK) == 16'h0000); // RULE2
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Receive default and active-set copy
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rx_dflt_q  <= 1'b1;
			act_dflt_q <= 1'b1; // RULE15
		end else if (clk_en) begin
			if (state_q == ST_CLEAR) begin
				rx_dflt_q <= 1'b1;
			end else if (wpend_q && state_q == ST_RX && widx_q == `RX_WORDS - 6'h01) begin
				rx_dflt_q <= 1'b0;
			end
			if (state_q == ST_IDLE && rx_mode_enter && !powersave) begin
				act_dflt_q <= rx_dflt_q; // RULE14
			end
		end
	end

	assign rx_default_mode = act_dflt_q;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cidx_q <= 6'h00;
			cvld_q <= 1'b0;
			cdst_q <= 5'h00;
		end else if (clk_en) begin
			cvld_q <= 1'b0;
			if (state_q != ST_COPY) begin
				cidx_q <= 6'h00;
			end else if (cidx_q != `RX_WORDS) begin
				cvld_q <= 1'b1;
				cdst_q <= cidx_q[4:0];
				cidx_q <= cidx_q + 6'h01;
			end
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < `RX_WORDS; gi++) begin : g_act
			always_ff @(posedge ref_clk or negedge nrst) begin
				if (!nrst) begin
					act_q[gi] <= 15'h0000;
				end else if (clk_en && cvld_q && cdst_q == 5'(gi)) begin
					act_q[gi] <= copy_rd[14:0]; // RULE14
				end
			end
			assign rx_coef_active[gi*15 +: 15] = act_q[gi];
		end
	endgenerate

	// ----------------------------------------------------------------
	// 9.6 kHz timer tick
	// ----------------------------------------------------------------
	logic [15:0] tick_cnt_q;
	logic        tick;

	assign tick = (tick_cnt_q == 16'(TICK_DIV - 1));

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			tick_cnt_q <= 16'h0000;
		end else if (clk_en) begin
			tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001; // RULE12
		end
	end

	// ----------------------------------------------------------------
	// Frequency and level detectors
	// ----------------------------------------------------------------
	generate
		for (gi = 0; gi < 2; gi++) begin : g_det
			logic [15:0] ncyc;
			logic [15:0] tmin;
			logic [15:0] tmax;
			logic [15:0] cyc_q;
			logic [15:0] time_q;
			logic [15:0] mag;

			assign mag = level_mag[gi*16 +: 16];
			always_comb begin
				if (act_dflt_q) begin
					ncyc = (gi == 0) ? DEF_NCYC1 : DEF_NCYC2; // RULE15
					tmin = (gi == 0) ? DEF_MIN1 : DEF_MIN2;
					tmax = (gi == 0) ? DEF_MAX1 : DEF_MAX2;
				end else begin
					ncyc = {1'b0, act_q[gi*`RX_SET_WORDS + `NCYC_OFS]};
					tmin = {1'b0, act_q[gi*`RX_SET_WORDS + `MINT_OFS]};
					tmax = {1'b0, act_q[gi*`RX_SET_WORDS + `MAXT_OFS]};
				end
			end

			// Timer saturates so a stalled input cannot wrap back into range
			always_ff @(posedge ref_clk or negedge nrst) begin
				if (!nrst) begin
					cyc_q        <= 16'h0000;
					time_q       <= 16'h0000;
					freq_ok[gi]  <= 1'b0;
				end else if (clk_en) begin
					if (cycle_done[gi] && cyc_q + 16'h0001 >= ncyc) begin
						freq_ok[gi] <= (time_q >= tmin) && (time_q <= tmax); // RULE11
						cyc_q       <= 16'h0000;
						time_q      <= 16'h0000;
					end else begin
						if (cycle_done[gi]) begin
							cyc_q <= cyc_q + 16'h0001;
						end
						if (tick && time_q != `TIMER_MAX) begin
							time_q <= time_q + 16'h0001; // RULE12
						end
					end
				end
			end

			always_ff @(posedge ref_clk or negedge nrst) begin
				if (!nrst) begin
					level_on[gi] <= 1'b0;
				end else if (clk_en) begin
					if (!level_on[gi] && mag >= LVL_ON_TH) begin
						level_on[gi] <= 1'b1; // RULE13
					end else if (level_on[gi] && mag < LVL_OFF_TH) begin
						level_on[gi] <= 1'b0; // RULE13
					end
				end
			end

			assign tone_det[gi] = freq_ok[gi] && level_on[gi]; // RULE20

			det_needs_both_a: assert property (@(posedge ref_clk) disable iff (!nrst)
				tone_det[gi] |-> (freq_ok[gi] && level_on[gi])) // RULE20
				else $error("tone reported without range and level");
			level_hyst_a: assert property (@(posedge ref_clk) disable iff (!nrst)
				(clk_en && level_on[gi] && mag >= LVL_OFF_TH) |=> level_on[gi]) // RULE13
				else $error("level detector dropped above off threshold");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	flag_write_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(clk_en && word_take) |=> !prog_flag) // RULE16
		else $error("flag still set after programming write");
	flag_return_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(clk_en && word_take && state_q != ST_IDLE && !hdr_word && !powersave)
		##1 clk_en [*2] |=> prog_flag) // RULE16
		else $error("flag not restored after word absorbed");
	tx_header_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(clk_en && !powersave && state_q != ST_CLEAR && state_q != ST_COPY && !rx_mode_enter
		&& word_take && prog_data == `HDR_TX) |=> (state_q == ST_TX && widx_q == 6'h00)) // RULE3
		else $error("transmit header did not start load");
	rx_header_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(clk_en && !powersave && state_q != ST_CLEAR && state_q != ST_COPY && !rx_mode_enter
		&& word_take && prog_data == `HDR_RX) |=> (state_q == ST_RX)) // RULE8
		else $error("receive header did not start load");
	clear_on_save_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(clk_en && powersave) |=> (state_q == ST_CLEAR && !prog_flag)) // RULE17
		else $error("powersave did not clear store");
	tx_store_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(mem_we && state_q == ST_TX) |-> (mem_wa < `TX_WORDS && mem_wd <= `TX_VAL_MASK)) // RULE4
		else $error("transmit word outside pair area");
	rx_store_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(mem_we && state_q == ST_RX) |-> (mem_wa >= `RX_BASE && mem_wa <= `MEM_LAST && !mem_wd[15])) // RULE9
		else $error("receive word outside detector area");
	active_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state_q == ST_RX) |=> $stable(act_dflt_q)) // RULE14
		else $error("active detector set changed during load");

endmodule : tone_pair_program_loader

// ---- pkg/tone_loader_params.svh ----
`ifndef TONE_LOADER_PARAMS_SVH
`define TONE_LOADER_PARAMS_SVH

// ----------------------------------------------------------------
// Programming port and word codes
// ----------------------------------------------------------------
`define PROG_ADDR        8'hE8
`define HDR_TX           16'h8000
`define HDR_RX           16'h8001
`define TX_VAL_MASK      16'h3FFF
`define RX_VAL_MASK      16'h7FFF
`define HDR_BIT          15

// ----------------------------------------------------------------
// Memory layout
// ----------------------------------------------------------------
`define TX_WORDS         6'd16
`define RX_WORDS         6'd26
`define RX_BASE          6'd16
`define MEM_LAST         6'd41
`define RX_SET_WORDS     13
`define NCYC_OFS         10
`define MINT_OFS         11
`define MAXT_OFS         12
`define TX_P4_BASE       6'd12

// ----------------------------------------------------------------
// Reset values for pair four (2130 Hz and 2750 Hz, -20 dBm at 3.3 V)
// ----------------------------------------------------------------
`define P4_F1_DEF        16'h1C68
`define P4_F2_DEF        16'h24AD
`define P4_LVL_DEF       16'h089A
`define SILENT_DEF       8'h3F

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_HZ           100000000
`define TICK_HZ          9600
`define TICK_CYCLES      ((`CLK_HZ + `TICK_HZ - 1) / `TICK_HZ)
`define TIMER_MAX        16'hFFFF

`endif

// ---- pkg/tone_loader_pkg.sv ----
package tone_loader_pkg;

	typedef enum logic [2:0] {
		ST_CLEAR = 3'b000,
		ST_IDLE  = 3'b001,
		ST_TX    = 3'b010,
		ST_RX    = 3'b011,
		ST_COPY  = 3'b100
	} load_state_e;

	typedef logic [14:0] coef_t;

endpackage : tone_loader_pkg

// ---- core/coef_mem.sv ----
`timescale 1ns/10ps
`include "tone_loader_params.svh"

// Tone programming store: one write port, two registered read ports
module coef_mem #(
	parameter int AW = 6,
	parameter int DW = 16
) (
	input  wire logic          ref_clk,
	input  wire logic          clk_en,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [DW-1:0] wr_data,
	input  wire logic [AW-1:0] rd_a_addr,
	output logic      [DW-1:0] rd_a_q,
	input  wire logic [AW-1:0] rd_b_addr,
	output logic      [DW-1:0] rd_b_q
);

	logic [DW-1:0] mem [0:(1<<AW)-1];

	// No reset on the array; the loader walks it at start-up instead
	always_ff @(posedge ref_clk) begin
		if (clk_en && wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (clk_en) begin
			rd_a_q <= mem[rd_a_addr];
			rd_b_q <= mem[rd_b_addr];
		end
	end

endmodule : coef_mem

// ---- test/host_model.sv ----
`timescale 1ns/10ps
`include "tone_loader_params.svh"

// ----------------------------------------------------------------
// Host writing the programming register
// ----------------------------------------------------------------
module host_model (
	input  wire logic        ref_clk,
	input  wire logic        prog_flag,
	output logic             prog_wr,
	output logic [7:0]       prog_addr,
	output logic [15:0]      prog_data
);
	// Extra idle cycles before each write, to model a slow host
	int gap = 0;

	initial begin
		prog_wr   = 1'b0;
		prog_addr = 8'h00;
		prog_data = 16'h0000;
	end

	function automatic logic [15:0] freq_code(input int hz);
		return 16'(int'(hz * 3.414));
	endfunction : freq_code

	function automatic logic [15:0] level_code(input real vrms, input real vdd);
		return 16'(int'(vrms * 93780.0 / vdd));
	endfunction : level_code

	// Bus lines are scrambled when released so stale data is never reused
	task automatic send(input logic [15:0] w);
		int n;
		n = 0;
		@(posedge ref_clk);
		while (prog_flag !== 1'b1 && n < 400) begin
			@(posedge ref_clk);
			n++;
		end
		repeat (gap) @(posedge ref_clk);
		prog_wr   <= 1'b1;
		prog_addr <= `PROG_ADDR;
		prog_data <= w;
		@(posedge ref_clk);
		prog_wr   <= 1'b0;
		prog_addr <= ~`PROG_ADDR;
		prog_data <= ~w;
	endtask : send

	task automatic load(input logic [15:0] hdr, input logic [15:0] w[$]);
		send(hdr);
		foreach (w[i]) send(w[i]);
	endtask : load
endmodule : host_model

// ---- test/tone_pair_program_loader_tb.sv ----
`timescale 1ns/10ps
`include "tone_loader_params.svh"

module tone_pair_program_loader_tb;
	localparam logic [15:0] ON_TH  = 16'h0100;
	localparam logic [15:0] OFF_TH = 16'h00C0;

	typedef struct {
		logic [15:0] wr;
		logic [15:0] rd;
	} tx_row_s;

	// ----------------------------------------------------------------
	// Transmit rows: word written, word read back
	// ----------------------------------------------------------------
	tx_row_s rows [16] = '{
		'{16'h0D56, 16'h0D56}, '{16'h3781, 16'h3781}, '{16'h1AAB, 16'h1AAB}, '{16'h4123, 16'h0123},
		'{16'h0D56, 16'h0D56}, '{16'h3781, 16'h3781}, '{16'h0000, 16'h0000}, '{16'h0000, 16'h0000},
		'{16'h0000, 16'h0000}, '{16'h0000, 16'h0000}, '{16'h0000, 16'h0000}, '{16'h0000, 16'h0000},
		'{16'h3FFF, 16'h3FFF}, '{16'h0001, 16'h0001}, '{16'h2000, 16'h2000}, '{16'h0100, 16'h0100}
	};

	logic           ref_clk;
	logic           nrst;
	logic           clk_en;
	logic           powersave;
	logic           prog_wr;
	logic [7:0]     prog_addr;
	logic [15:0]    prog_data;
	logic           prog_flag;
	logic [3:0]     tx_rd_idx;
	logic [15:0]    tx_rd_data;
	logic [7:0]     tx_tone_silent;
	logic           rx_mode_enter;
	logic [389:0]   rx_coef_active;
	logic           rx_default_mode;
	logic [1:0]     cycle_done;
	logic [31:0]    level_mag;
	logic [1:0]     level_on;
	logic [1:0]     freq_ok;
	logic [1:0]     tone_det;
	int             fail_count = 0;
	int             check_count = 0;
	logic [15:0]    txq[$];
	logic [15:0]    rxq[$];

	always #5 ref_clk = ~ref_clk;

	host_model host (
		.ref_clk   (ref_clk),
		.prog_flag (prog_flag),
		.prog_wr   (prog_wr),
		.prog_addr (prog_addr),
		.prog_data (prog_data)
	);

	// Short tick divider keeps detector timings to a few dozen cycles
	tone_pair_program_loader #(
		.TICK_DIV   (4),
		.LVL_ON_TH  (ON_TH),
		.LVL_OFF_TH (OFF_TH)
	) dut (
		.ref_clk         (ref_clk),
		.nrst            (nrst),
		.clk_en          (clk_en),
		.powersave       (powersave),
		.prog_wr         (prog_wr),
		.prog_addr       (prog_addr),
		.prog_data       (prog_data),
		.prog_flag       (prog_flag),
		.tx_rd_en        (1'b1),
		.tx_rd_idx       (tx_rd_idx),
		.tx_rd_data      (tx_rd_data),
		.tx_tone_silent  (tx_tone_silent),
		.rx_mode_enter   (rx_mode_enter),
		.rx_coef_active  (rx_coef_active),
		.rx_default_mode (rx_default_mode),
		.cycle_done      (cycle_done),
		.level_mag       (level_mag),
		.level_on        (level_on),
		.freq_ok         (freq_ok),
		.tone_det        (tone_det)
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out

	task automatic wait_flag();
		int n;
		n = 0;
		repeat (2) @(posedge ref_clk);
		while (prog_flag !== 1'b1 && n < 200) begin
			@(posedge ref_clk);
			n++;
		end
		@(negedge ref_clk);
		chk("prog_flag", 16'h0001, {15'h0, prog_flag});
	endtask : wait_flag

	task automatic rd(input logic [3:0] idx, input logic [15:0] exp);
		@(posedge ref_clk);
		tx_rd_idx <= idx;
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		chk("tx_rd_data", exp, tx_rd_data);
	endtask : rd

	task automatic lvl(input logic [15:0] v, input logic on);
		@(posedge ref_clk);
		level_mag <= {v, v};
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		chk("level_on", {14'h0, on, on}, {14'h0, level_on});
	endtask : lvl

	// Pulses are sp cycles apart, the first sp cycles after the previous completion,
	// so the measured span is a whole number of spacings whatever the tick phase
	task automatic measure(input int d, input int sp, input logic f, input logic t);
		repeat (d == 0 ? 3 : 2) begin
			repeat (sp - 1) @(posedge ref_clk);
			cycle_done[d] <= 1'b1;
			@(posedge ref_clk);
			cycle_done[d] <= 1'b0;
		end
		@(negedge ref_clk);
		chk("freq_ok", {15'h0, f}, {15'h0, freq_ok[d]});
		chk("tone_det", {15'h0, t}, {15'h0, tone_det[d]});
	endtask : measure

	function automatic logic [15:0] rx_word(input int i);
		case (i)
			0:       return 16'h5000;
			10:      return 16'h0003;
			11:      return 16'h0003;
			12:      return 16'h0006;
			23:      return 16'h0002;
			24:      return 16'h0003;
			25:      return 16'h0009;
			default: return 16'h0100 + 16'(i);
		endcase
	endfunction : rx_word

	initial begin
		#200us;
		fail_count++;
		close_out();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		nrst = 1'b0;
		clk_en = 1'b1;
		powersave = 1'b0;
		tx_rd_idx = 4'h0;
		rx_mode_enter = 1'b0;
		cycle_done = 2'b00;
		level_mag = 32'h0000_0000;
		repeat (1) @(posedge ref_clk);
		@(negedge ref_clk);
		chk("prog_flag", 16'h0000, {15'h0, prog_flag});
		chk("tx_tone_silent", 16'h003F, {8'h00, tx_tone_silent});
		chk("freq_code", 16'h0D56, host.freq_code(1000));
		chk("level_code", 16'h3781, host.level_code(0.5, 3.3));
		chk("rx_default_mode", 16'h0001, {15'h0, rx_default_mode});
		@(posedge ref_clk);
		nrst <= 1'b1;
		wait_flag();
		for (int i = 0; i < 16; i++) begin
			rd(4'(i), i == 12 ? `P4_F1_DEF : i == 14 ? `P4_F2_DEF : i > 12 ? `P4_LVL_DEF : 16'h0000);
		end
		foreach (rows[i]) txq.push_back(rows[i].wr);
		host.load(`HDR_TX, txq);
		wait_flag();
		foreach (rows[i]) begin
			rd(4'(i), rows[i].rd);
		end
		chk("tx_tone_silent", 16'h0038, {8'h00, tx_tone_silent});
		host.gap = 4;
		for (int i = 0; i < 26; i++) rxq.push_back(rx_word(i));
		host.load(`HDR_RX, rxq);
		wait_flag();
		chk("rx_coef_active", 16'h0000, {1'b0, rx_coef_active[14:0]});
		chk("rx_default_mode", 16'h0001, {15'h0, rx_default_mode});
		@(posedge ref_clk);
		rx_mode_enter <= 1'b1;
		@(posedge ref_clk);
		rx_mode_enter <= 1'b0;
		wait_flag();
		for (int i = 0; i < 26; i++) begin
			chk("rx_coef_active", rxq[i], {1'b0, rx_coef_active[i*15+:15]});
		end
		chk("rx_default_mode", 16'h0000, {15'h0, rx_default_mode});
		lvl(ON_TH - 16'h0001, 1'b0);
		lvl(ON_TH, 1'b1);
		lvl(OFF_TH, 1'b1);
		measure(0, 14, 1'b0, 1'b0);
		measure(0, 6, 1'b1, 1'b1);
		measure(0, 2, 1'b0, 1'b0);
		measure(1, 30, 1'b0, 1'b0);
		measure(1, 14, 1'b1, 1'b1);
		lvl(OFF_TH - 16'h0001, 1'b0);
		measure(1, 14, 1'b1, 1'b0);
		rd(4'h1, 16'h3781);
		@(posedge ref_clk);
		clk_en <= 1'b0;
		tx_rd_idx <= 4'h0;
		repeat (3) @(negedge ref_clk);
		chk("tx_rd_data", 16'h3781, tx_rd_data);
		@(posedge ref_clk);
		clk_en <= 1'b1;
		powersave <= 1'b1;
		repeat (3) @(negedge ref_clk);
		chk("prog_flag", 16'h0000, {15'h0, prog_flag});
		chk("tx_tone_silent", 16'h003F, {8'h00, tx_tone_silent});
		@(posedge ref_clk);
		powersave <= 1'b0;
		wait_flag();
		rd(4'h0, 16'h0000);
		rd(4'hC, `P4_F1_DEF);
		close_out();
	end
endmodule : tone_pair_program_loader_tb
